// ---- hw/dam_pkg.sv ----
// Shared constants and checksum function for the accelerometer message layer
package dam_pkg;
  localparam int MSG_BITS = 48;
  localparam int BYTE_W = 8;
  localparam int DATA_BITS = 32;
  localparam int WORD_W = 16;
  localparam logic [5:0] BITCNT_FULL = 6'h30;
  localparam logic [5:0] BITCNT_MAX = 6'h3F;
  localparam int SMP_W = 48;
  localparam int FIFO_DEPTH = 8;
  // Request command fields
  localparam logic [3:0] REQ_ACC = 4'h1;
  localparam logic [3:0] REQ_STAT = 4'h2;
  localparam int CMD_ST_BIT = 6;
  localparam int CMD_MSB = 47;
  localparam int CMD_LSB = 40;
  // Response type codes in the status byte
  localparam logic [2:0] TYPE_ACC = 3'h1;
  localparam logic [2:0] TYPE_STAT = 3'h2;
  localparam int RESP_TYPE_LSB = 40;
  localparam int RESP_ST_BIT = 43;
  localparam int RESP_ERR_BIT = 44;
  localparam int RESP_D1_MSB = 39;
  localparam int RESP_D1_LSB = 24;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic STAT_BIT0 = 1'b1;
  localparam logic [15:0] ST_OFFSET_DEF = 16'h0100;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [47:0] MSG_ZERO = 48'h0000_0000_0000;

  // Low byte of the ones complement of the sum of five bytes
  function automatic logic [7:0] msg_cks(input logic [39:0] m);
    logic [10:0] s;
    s = 11'h000;
    for (int i = 0; i < 5; i++) begin
      s = s + {3'h0, m[i*8 +: 8]};
    end
    return ~s[7:0];
  endfunction
endpackage

// ---- hw/dam_fifo.sv ----
// Sample FIFO between the sensing front end and the message layer
module dam_fifo #(
  parameter int W = 48,
  parameter int D = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
  localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;
  assign o_data = mem[rd_ptr];

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_cnt = cnt - (AW+1)'(1);
    end
  end

  // Flags are registered so the full/empty view never glitches
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= '0;
      o_ready <= 1'b1;
      o_valid <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      o_ready <= next_cnt != CNT_FULL;
      o_valid <= next_cnt != '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  fifo_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cnt <= CNT_FULL)
    else $error("fifo count beyond depth");
endmodule

// ---- hw/dam_msg.sv ----
// Message layer of a dual-axis accelerometer serial slave port
module dam_msg
  import dam_pkg::*;
#(
  parameter int SMP_WIDTH = dam_pkg::SMP_W,
  parameter int DEPTH = dam_pkg::FIFO_DEPTH,
  parameter logic [15:0] ST_OFFSET = dam_pkg::ST_OFFSET_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_cs_n,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_smp_valid,
  input wire logic [dam_pkg::SMP_W-1:0] i_smp_data,
  output logic o_smp_ready,
  input wire logic i_y_fail,
  input wire logic i_x_fail,
  input wire logic i_vref_fail,
  input wire logic i_cap_fail,
  input wire logic i_parity_fail,
  output logic o_selftest,
  output logic o_cksum_err
);
  import dam_pkg::*;

  // Pin synchronisers: the first stage feeds only the second
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic sclk_m;
  logic sclk_s;
  logic sclk_d;
  logic mosi_m;
  logic mosi_s;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      mosi_m <= 1'b1;
      mosi_s <= 1'b1;
    end else if (i_ce) begin
      cs_m <= i_cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sclk_m <= i_sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      mosi_m <= i_mosi;
      mosi_s <= mosi_m;
    end
  end

  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;

  assign frame_start = i_ce && cs_d && !cs_s;
  assign frame_end = i_ce && !cs_d && cs_s;
  // Mode 0: take input on rising edges, move output on falling edges
  assign sclk_rise = i_ce && !cs_s && sclk_s && !sclk_d;
  assign sclk_fall = i_ce && !cs_s && !sclk_s && sclk_d;

  // Sample path
  logic smp_valid;
  logic [SMP_WIDTH-1:0] smp_data;
  logic smp_pop;

  // Only one sample is taken per frame, so a slow host backs up the FIFO
  assign smp_pop = frame_end && smp_valid;

  dam_fifo #(
    .W(SMP_WIDTH),
    .D(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_smp_valid),
    .i_data(i_smp_data),
    .o_ready(o_smp_ready),
    .o_valid(smp_valid),
    .o_data(smp_data),
    .i_ready(smp_pop)
  );

  // Receive side
  logic [MSG_BITS-1:0] rx;
  logic [5:0] bit_cnt;
  logic rx_good;
  logic [7:0] rx_cmd;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx <= MSG_ZERO;
      bit_cnt <= '0;
    end else if (i_ce) begin
      if (frame_start) begin
        bit_cnt <= '0;
      end else if (sclk_rise) begin
        rx <= {rx[MSG_BITS-2:0], mosi_s};
        // Saturate so an overlong frame cannot wrap back to a full count
        if (bit_cnt != BITCNT_MAX) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
      end
    end
  end

  assign rx_cmd = rx[CMD_MSB:CMD_LSB];
  // Data bytes are not checked for zero; only length and sum decide
  assign rx_good = (bit_cnt == BITCNT_FULL)
                 && (msg_cks(rx[MSG_BITS-1:BYTE_W]) == rx[BYTE_W-1:0]);

  // Request state kept between frames
  logic [2:0] req_type;
  logic selftest;
  logic cksum_err;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_type <= TYPE_ACC;
      selftest <= 1'b0;
      cksum_err <= 1'b0;
    end else if (frame_end) begin
      if (rx_good) begin
        cksum_err <= 1'b0;
        selftest <= rx_cmd[CMD_ST_BIT];
        if (rx_cmd[3:0] == REQ_ACC) begin
          req_type <= TYPE_ACC;
        end else if (rx_cmd[3:0] == REQ_STAT) begin
          req_type <= TYPE_STAT;
        end
      end else begin
        cksum_err <= 1'b1;
      end
    end
  end

  // Frozen measurement words, updated only between frames
  logic [WORD_W-1:0] y_frz;
  logic [WORD_W-1:0] x_frz;
  logic [WORD_W-1:0] t_frz;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      y_frz <= WORD_ZERO;
      x_frz <= WORD_ZERO;
      t_frz <= WORD_ZERO;
    end else if (smp_pop) begin
      y_frz <= smp_data[3*WORD_W-1:2*WORD_W];
      x_frz <= smp_data[2*WORD_W-1:WORD_W];
      t_frz <= smp_data[WORD_W-1:0];
    end
  end

  // Response assembly
  logic bit_fail;
  logic [7:0] status;
  logic [7:0] stat_d1;
  logic [WORD_W-1:0] y_out;
  logic [WORD_W-1:0] x_out;
  logic [DATA_BITS-1:0] data;
  logic [MSG_BITS-1:0] resp;

  assign bit_fail = i_y_fail || i_x_fail || i_vref_fail || i_cap_fail
                  || i_parity_fail;
  assign status = {bit_fail, i_y_fail, i_x_fail, cksum_err, selftest,
                   req_type};
  assign stat_d1 = {i_x_fail, i_y_fail, i_vref_fail, i_cap_fail, selftest,
                    i_parity_fail, cksum_err, STAT_BIT0};
  // Wrapping add keeps the two's complement form of the offset sum
  assign y_out = selftest ? y_frz + ST_OFFSET : y_frz;
  assign x_out = selftest ? x_frz + ST_OFFSET : x_frz;

  always_comb begin
    if (req_type == TYPE_STAT) begin
      data = {stat_d1, BYTE_ZERO, t_frz};
    end else begin
      data = {y_out, x_out};
    end
  end

  assign resp = {status, data, msg_cks({status, data})};

  // Transmit side
  logic [MSG_BITS-1:0] tx;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx <= MSG_ZERO;
      o_miso <= 1'b0;
    end else if (frame_start) begin
      tx <= resp;
      o_miso <= resp[MSG_BITS-1];
    end else if (sclk_fall) begin
      tx <= {tx[MSG_BITS-2:0], 1'b0};
      o_miso <= tx[MSG_BITS-2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_miso_oe <= 1'b0;
      o_selftest <= 1'b0;
      o_cksum_err <= 1'b0;
    end else if (i_ce) begin
      o_miso_oe <= !cs_s;
      o_selftest <= selftest;
      o_cksum_err <= cksum_err;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  miso_enable_a: assert property (
    i_ce && $past(i_ce) |-> o_miso_oe == !$past(cs_s))
    else $error("data out enable does not follow select");

  tx_load_a: assert property (
    frame_start |=> tx == $past(resp) && o_miso == $past(resp[MSG_BITS-1]))
    else $error("response not loaded at frame start");

  tx_cks_a: assert property (
    frame_start |-> resp[BYTE_W-1:0]
      == msg_cks(resp[MSG_BITS-1:BYTE_W]))
    else $error("response checksum wrong");

  power_type_a: assert property (
    $past(i_rst) |-> req_type == TYPE_ACC && !cksum_err)
    else $error("type after reset is not acceleration");

  bad_flag_a: assert property (
    frame_end && !rx_good |=> cksum_err ##1 cksum_err || frame_end)
    else $error("bad request checksum not flagged");

  type_hold_a: assert property (
    frame_end && !rx_good |=> $stable(req_type) && $stable(selftest))
    else $error("discarded request changed the type");

  status_type_a: assert property (
    frame_start |-> resp[RESP_TYPE_LSB+2:RESP_TYPE_LSB] == req_type
      && resp[RESP_ST_BIT] == selftest && resp[RESP_ERR_BIT] == cksum_err)
    else $error("status byte fields wrong");

  good_type_a: assert property (
    frame_end && rx_good && rx_cmd[3:0] == REQ_STAT |=> req_type == TYPE_STAT)
    else $error("good status request not taken");

  st_offset_a: assert property (
    frame_start && selftest && req_type == TYPE_ACC
      |-> resp[RESP_D1_MSB:RESP_D1_LSB] == WORD_W'(y_frz + ST_OFFSET))
    else $error("self-test offset missing");

  shift_a: assert property (
    sclk_fall && !frame_start |=> o_miso == $past(tx[MSG_BITS-2]))
    else $error("serial output not shifted on falling edge");

  // A change outside a frame end would break the request/response pairing
  req_idle_a: assert property (
    !frame_end |=> $stable(req_type) && $stable(selftest)
      && $stable(cksum_err))
    else $error("request state changed outside a frame end");

  // A low enable must freeze the link state as well as the buffer
  ce_freeze_a: assert property (
    !i_ce |=> $stable(bit_cnt) && $stable(tx) && $stable(o_miso_oe))
    else $error("state moved while clock enable was low");
endmodule

// ---- dv/dam_host_model.sv ----
// Host serial master model issuing mode 0 frames
module dam_host_model (
  input wire logic i_clk,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b1;
    o_cs_n = 1'b1;
  end
  // Four clocks a half period give the 64 ns link clock
  task automatic xfer(input logic [47:0] tx, output logic [47:0] rx);
    rx = 48'h0;
    o_cs_n <= 1'b0;
    for (int i = 47; i >= 0; i--) begin
      o_mosi <= tx[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      @(posedge i_clk);
      // Released line reads as the inverse of the last bit
      rx = {rx[46:0], i_miso_oe ? i_miso : ~rx[0]};
      repeat (3) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= 1'b1;
  endtask
endmodule

// ---- dv/dam_msg_tb.sv ----
// Self-checking bench for the message layer with a host model
module dam_msg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dam_pkg::*;
  localparam logic [15:0] OFS = 16'h0100;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic i_smp_valid = 1'b0;
  logic [47:0] i_smp_data = 48'h0;
  logic [4:0] flt = 5'h00; // y, x, vref, cap, parity
  logic sclk, mosi, cs_n, miso, miso_oe, smp_ready, selftest, cksum_err;
  int mismatches = 0;
  int comparisons = 0;
  logic [2:0] ty = 3'h1;
  logic st = 1'b0;
  logic er = 1'b0;
  logic [47:0] smp = 48'h0;
  logic [47:0] q[$];

  always #4 i_clk = ~i_clk;

  dam_msg #(.SMP_WIDTH(48), .DEPTH(8), .ST_OFFSET(OFS)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_sclk(sclk),
    .i_mosi(mosi), .i_cs_n(cs_n), .o_miso(miso), .o_miso_oe(miso_oe),
    .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
    .o_smp_ready(smp_ready), .i_y_fail(flt[4]), .i_x_fail(flt[3]),
    .i_vref_fail(flt[2]), .i_cap_fail(flt[1]), .i_parity_fail(flt[0]),
    .o_selftest(selftest), .o_cksum_err(cksum_err));

  dam_host_model host_u (.i_clk(i_clk), .i_miso(miso),
    .i_miso_oe(miso_oe), .o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n));

  function automatic logic [7:0] sum5(input logic [39:0] m);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 5; i++) begin
      s = s + m[i*8 +: 8];
    end
    return ~s;
  endfunction

  function automatic logic [47:0] resp(input logic [47:0] s);
    logic [39:0] m;
    logic [15:0] o;
    o = st ? OFS : 16'h0000;
    m[39:32] = {|flt, flt[4], flt[3], er, st, ty};
    if (ty == 3'h1) begin
      m[31:0] = {s[47:32] + o, s[31:16] + o};
    end else begin
      m[31:24] = {flt[3], flt[4], flt[2:1], st, flt[0], er, 1'b1};
      m[23:0] = {8'h00, s[15:0]};
    end
    return {m, sum5(m)};
  endfunction

  task automatic cmp48(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input logic bad);
    logic [39:0] m;
    logic [47:0] rx;
    logic [47:0] ex;
    m = {cmd, 32'h0};
    ex = resp(smp);
    host_u.xfer({m, sum5(m) ^ {7'h00, bad}}, rx);
    cmp48(rx, ex);
    er = bad;
    if (!bad) begin
      if (cmd[3:0] == 4'h1 || cmd[3:0] == 4'h2) begin
        ty = cmd[2:0];
      end
      st = cmd[6];
    end
    if (q.size() > 0) begin
      smp = q.pop_front();
    end
    repeat (8) @(posedge i_clk);
    cmp1(cksum_err, er);
    cmp1(selftest, st);
    cmp1(miso_oe, 1'b0);
  endtask

  task automatic sc_reset;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    cmp1(smp_ready, 1'b1);
    cmp1(miso_oe, 1'b0);
    cmp1(selftest, 1'b0);
  endtask

  // Far side stalls while the buffer fills until it refuses
  task automatic sc_fill;
    logic [47:0] d;
    // A stray word offered while the enable is low must never be stored
    ce <= 1'b0;
    i_smp_valid <= 1'b1;
    i_smp_data <= 48'hA5A5_5A5A_A5A5;
    repeat (4) @(posedge i_clk);
    ce <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      d = {16'hFF00 + 16'(k), 16'h7F00 + 16'(k), 16'h0C00 + 16'(k)};
      q.push_back(d);
      i_smp_valid <= 1'b1;
      i_smp_data <= d;
      @(posedge i_clk);
    end
    i_smp_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    cmp1(smp_ready, 1'b0);
  endtask

  task automatic sc_types;
    frame(8'h01, 1'b0);
    cmp1(smp_ready, 1'b1);
    frame(8'h42, 1'b0);
  endtask

  task automatic sc_bad;
    frame(8'h41, 1'b1);
    frame(8'h41, 1'b0);
  endtask

  task automatic sc_selftest;
    frame(8'h01, 1'b0);
    frame(8'h02, 1'b0);
  endtask

  task automatic sc_faults;
    flt <= 5'b10101;
    @(posedge i_clk);
    frame(8'h01, 1'b0);
    flt <= 5'b01010;
    @(posedge i_clk);
    frame(8'h02, 1'b0);
    flt <= 5'h00;
    @(posedge i_clk);
    frame(8'h01, 1'b0);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    complete_run();
  end

  initial begin
    sc_reset();
    sc_fill();
    sc_types();
    sc_bad();
    sc_selftest();
    sc_faults();
    complete_run();
  end
endmodule
